// ### common/dtfe_pkg.sv
// Constants and carrier types for the DS3 transmit F-bit error / overhead insert stage.
// Assumes one 100 MHz transmit clock shared by upstream logic and this stage.
package dtfe_pkg;
  localparam int unsigned REG_ADDR_W = 8;
  localparam int unsigned REG_DATA_W = 8;
  localparam logic [7:0] REG_MASK_OFS = 8'h00;
  localparam logic [7:0] REG_TEST_OFS = 8'h01;
  localparam logic [7:0] REG_STATUS_OFS = 8'h02;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h00;
  localparam int unsigned OHSEL_BIT = 7;
  localparam int unsigned FIELD_N = 6;

  // Position codes of a bit within the outbound frame
  localparam logic [3:0] POS_PAYLOAD = 4'h0;
  localparam logic [3:0] POS_F1 = 4'h1;
  localparam logic [3:0] POS_F6 = 4'h6;
  localparam logic [3:0] POS_F8 = 4'h8;
  localparam logic [3:0] POS_X1 = 4'h9;
  localparam logic [3:0] POS_C11 = 4'hA;
  localparam logic [3:0] POS_C12 = 4'hB;
  localparam logic [3:0] POS_C13 = 4'hC;
  localparam logic [3:0] POS_X2 = 4'hD;
  localparam logic [3:0] POS_C21 = 4'hE;

  typedef struct packed {
    logic [3:0] pos;
    logic data;
  } dtfe_bit_t;

  typedef struct packed {
    logic [REG_ADDR_W-1:0] addr;
    logic [REG_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } dtfe_reg_req_t;
endpackage

// ### rtl/dtfe_tx_oh.sv
// DS3 transmit stage: F-bit error injection or external overhead insertion.
// Assumes upstream logic on sys_clk_in presents the external overhead bit with its word.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Test bit 7 picks error or insert mode
// - Mode 0: field 5 XORs sixth F-bit
// - Mode 0: field 4 XORs fifth F-bit
// - Mode 0: field 3 XORs fourth F-bit
// - Mode 0: field 2 XORs third F-bit
// - Mode 0: field 1 XORs second F-bit
// - Mode 0: field 0 XORs first F-bit
// - Mode 1: field 5 zero takes C21 externally
// - Mode 1: field 4 zero takes X2 externally
// - Mode 1: field 3 zero takes C13 externally
// - Mode 1: field 2 zero takes C12 externally
// - Mode 1: field 1 zero takes C11 externally
// - Mode 1: field 0 zero takes X1 externally
module dtfe_tx_oh import dtfe_pkg::*; #(
  parameter int unsigned ADDR_W = REG_ADDR_W
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire dtfe_reg_req_t reg_req_in,
  output logic [REG_DATA_W-1:0] reg_rdata_out,
  input wire logic s_valid_in,
  output logic s_ready_out,
  input wire dtfe_bit_t s_word_in,
  input wire logic ext_oh_bit_in,
  output logic m_valid_out,
  input wire logic m_ready_in,
  output dtfe_bit_t m_word_out
);

  if (ADDR_W != REG_ADDR_W) begin : g_chk
    $error("dtfe_tx_oh: ADDR_W must equal REG_ADDR_W");
  end

  logic [7:0] mask_r;
  logic [7:0] test_r;
  logic [REG_DATA_W-1:0] rdata_r;
  logic out_v_r;
  dtfe_bit_t out_r;
  logic skid_v_r;
  dtfe_bit_t skid_r;
  logic ready_r;

  // Register decode
  wire hit_mask = reg_req_in.addr == REG_MASK_OFS;
  wire hit_test = reg_req_in.addr == REG_TEST_OFS;
  wire hit_stat = reg_req_in.addr == REG_STATUS_OFS;
  wire wr_mask = reg_req_in.wr && hit_mask;
  wire wr_test = reg_req_in.wr && hit_test;
  wire oh_sel = test_r[OHSEL_BIT];
  wire [7:0] status_w = {6'h00, skid_v_r, out_v_r};
  wire [7:0] rd_sel_w;
  assign rd_sel_w = hit_mask ? mask_r :
                    hit_test ? test_r :
                    hit_stat ? status_w : 8'h00;

  // Field index per bit position; one per covered bit
  wire is_fbit = (s_word_in.pos >= POS_F1) && (s_word_in.pos <= POS_F6);
  wire is_oh = (s_word_in.pos >= POS_X1) && (s_word_in.pos <= POS_C21);
  wire [3:0] f_idx = s_word_in.pos - POS_F1;
  wire [3:0] o_idx = s_word_in.pos - POS_X1;
  wire [2:0] fld_idx = is_fbit ? f_idx[2:0] : o_idx[2:0];
  wire fld = mask_r[fld_idx];

  // Mode 0 flips a chosen F-bit; mode 1 swaps in the upstream bit when enabled
  wire err_bit = s_word_in.data ^ fld;
  wire ins_bit = fld ? s_word_in.data : ext_oh_bit_in;
  wire proc_data = (!oh_sel && is_fbit) ? err_bit :
                   (oh_sel && is_oh) ? ins_bit : s_word_in.data;
  dtfe_bit_t proc_w;
  assign proc_w = '{pos: s_word_in.pos, data: proc_data};

  // Two-entry skid buffer; a stalled receiver fills the skid slot, then ready drops
  wire accept = s_valid_in && ready_r;
  wire drain = out_v_r && m_ready_in;
  wire out_free = !out_v_r || drain;
  wire direct_load = accept && out_free;
  wire out_v_nxt = out_free ? (skid_v_r || accept) : 1'b1;
  wire skid_v_nxt = out_free ? 1'b0 : (skid_v_r || accept);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      mask_r <= MASK_RST;
      test_r <= TEST_RST;
      rdata_r <= '0;
    end else begin
      if (wr_mask) begin
        mask_r <= reg_req_in.wdata;
      end
      if (wr_test) begin
        test_r <= reg_req_in.wdata;
      end
      rdata_r <= reg_req_in.rd ? rd_sel_w : '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      out_v_r <= 1'b0;
      out_r <= '0;
      skid_v_r <= 1'b0;
      skid_r <= '0;
      ready_r <= 1'b0;
    end else begin
      out_v_r <= out_v_nxt;
      skid_v_r <= skid_v_nxt;
      ready_r <= !skid_v_nxt;
      if (out_free && skid_v_r) begin
        out_r <= skid_r;
      end else if (direct_load) begin
        out_r <= proc_w;
      end
      if (accept && !out_free) begin
        skid_r <= proc_w;
      end
    end
  end

  assign reg_rdata_out = rdata_r;
  assign s_ready_out = ready_r;
  assign m_valid_out = out_v_r;
  assign m_word_out = out_r;

  // Checks
  mode_sel_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && test_r[OHSEL_BIT] && s_word_in.pos >= POS_F1 && s_word_in.pos <= POS_F8
    |=> m_word_out.data == $past(s_word_in.data))
    else $error("F-bit altered in insert mode");
  fbit_six_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && !test_r[OHSEL_BIT] && s_word_in.pos == POS_F6
    |=> m_word_out.data == ($past(s_word_in.data) ^ $past(mask_r[5])))
    else $error("sixth F-bit error wrong");
  fbit_five_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && !test_r[OHSEL_BIT] && s_word_in.pos == 4'h5
    |=> m_word_out.data == ($past(s_word_in.data) ^ $past(mask_r[4])))
    else $error("fifth F-bit error wrong");
  fbit_four_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && !test_r[OHSEL_BIT] && s_word_in.pos == 4'h4
    |=> m_word_out.data == ($past(s_word_in.data) ^ $past(mask_r[3])))
    else $error("fourth F-bit error wrong");
  fbit_three_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && !test_r[OHSEL_BIT] && s_word_in.pos == 4'h3
    |=> m_word_out.data == ($past(s_word_in.data) ^ $past(mask_r[2])))
    else $error("third F-bit error wrong");
  fbit_two_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && !test_r[OHSEL_BIT] && s_word_in.pos == 4'h2
    |=> m_word_out.data == ($past(s_word_in.data) ^ $past(mask_r[1])))
    else $error("second F-bit error wrong");
  fbit_one_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && !test_r[OHSEL_BIT] && s_word_in.pos == POS_F1
    |=> m_word_out.data == ($past(s_word_in.data) ^ $past(mask_r[0])))
    else $error("first F-bit error wrong");
  ins_c21_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && test_r[OHSEL_BIT] && s_word_in.pos == POS_C21
    |=> m_word_out.data == ($past(mask_r[5]) ? $past(s_word_in.data) : $past(ext_oh_bit_in)))
    else $error("C21 insert wrong");
  ins_x2_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && test_r[OHSEL_BIT] && s_word_in.pos == POS_X2
    |=> m_word_out.data == ($past(mask_r[4]) ? $past(s_word_in.data) : $past(ext_oh_bit_in)))
    else $error("X2 insert wrong");
  ins_c13_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && test_r[OHSEL_BIT] && s_word_in.pos == POS_C13
    |=> m_word_out.data == ($past(mask_r[3]) ? $past(s_word_in.data) : $past(ext_oh_bit_in)))
    else $error("C13 insert wrong");
  ins_c12_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && test_r[OHSEL_BIT] && s_word_in.pos == POS_C12
    |=> m_word_out.data == ($past(mask_r[2]) ? $past(s_word_in.data) : $past(ext_oh_bit_in)))
    else $error("C12 insert wrong");
  ins_c11_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && test_r[OHSEL_BIT] && s_word_in.pos == POS_C11
    |=> m_word_out.data == ($past(mask_r[1]) ? $past(s_word_in.data) : $past(ext_oh_bit_in)))
    else $error("C11 insert wrong");
  ins_x1_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && test_r[OHSEL_BIT] && s_word_in.pos == POS_X1
    |=> m_word_out.data == ($past(mask_r[0]) ? $past(s_word_in.data) : $past(ext_oh_bit_in)))
    else $error("X1 insert wrong");
  stall_hold_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    m_valid_out && !m_ready_in |=> m_valid_out && $stable(m_word_out))
    else $error("output changed while stalled");
  mask_read_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    reg_req_in.rd && hit_mask && !reg_req_in.wr |=> reg_rdata_out == $past(mask_r))
    else $error("mask readback wrong");

  // Bits outside the selected mode must leave untouched; an enabled F6 field flips and an enabled X1 field takes the outside bit
  pay_pass_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && s_word_in.pos == POS_PAYLOAD
    |=> m_word_out.data == $past(s_word_in.data))
    else $error("payload bit altered");

  oh_err_pass_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && !test_r[OHSEL_BIT] && s_word_in.pos >= POS_X1
    |=> m_word_out.data == $past(s_word_in.data))
    else $error("overhead bit altered in error mode");

  f78_err_pass_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && !test_r[OHSEL_BIT] && s_word_in.pos > POS_F6 && s_word_in.pos <= POS_F8
    |=> m_word_out.data == $past(s_word_in.data))
    else $error("uncovered F-bit altered");

  unused_pass_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && test_r[OHSEL_BIT] && s_word_in.pos == 4'hF
    |=> m_word_out.data == $past(s_word_in.data))
    else $error("unused position altered");

  err_zero_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && !test_r[OHSEL_BIT] && mask_r[5:0] == 6'h00
    |=> m_word_out.data == $past(s_word_in.data))
    else $error("zero mask still altered a bit");

  ins_off_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && test_r[OHSEL_BIT] && mask_r[5:0] == 6'h3F
    |=> m_word_out.data == $past(s_word_in.data))
    else $error("disabled insert still took outside bit");

  c21_keep_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && test_r[OHSEL_BIT] && s_word_in.pos == POS_C21 && mask_r[5]
    |=> m_word_out.data == $past(s_word_in.data))
    else $error("C21 replaced while disabled");

  x1_ext_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && test_r[OHSEL_BIT] && s_word_in.pos == POS_X1 && !mask_r[0]
    |=> m_word_out.data == $past(ext_oh_bit_in))
    else $error("X1 not taken from outside");

  f6_flip_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load && !test_r[OHSEL_BIT] && s_word_in.pos == POS_F6 && mask_r[5]
    |=> m_word_out.data != $past(s_word_in.data))
    else $error("sixth F-bit not flipped");

  // Buffer keeps order and loses nothing
  pos_keep_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load
    |=> m_word_out.pos == $past(s_word_in.pos))
    else $error("position code changed");

  load_valid_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    direct_load
    |=> m_valid_out)
    else $error("loaded word not valid");

  skid_fill_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    accept && !out_free
    |=> skid_v_r)
    else $error("stalled word not parked");

  skid_pos_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    accept && !out_free
    |=> skid_r.pos == $past(s_word_in.pos))
    else $error("parked word position wrong");

  skid_move_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    out_free && skid_v_r
    |=> m_valid_out && m_word_out == $past(skid_r))
    else $error("parked word not moved out");

  skid_out_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    skid_v_r
    |-> m_valid_out)
    else $error("parked word behind empty output");

  skid_hold_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    skid_v_r && !out_free
    |=> skid_v_r && $stable(skid_r))
    else $error("parked word changed while stalled");

  skid_clear_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    out_free
    |=> !skid_v_r)
    else $error("parked slot not freed");

  drain_empty_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    drain && !skid_v_r && !accept
    |=> !m_valid_out)
    else $error("valid held after last word");

  ready_rise_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    out_free
    |=> s_ready_out)
    else $error("ready not given with free slots");

  ready_drop_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    accept && !out_free
    |=> !s_ready_out)
    else $error("ready kept with both slots full");

  ready_skid_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    skid_v_r
    |-> !s_ready_out)
    else $error("ready while parked slot full");

  // Register port
  rdata_idle_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !reg_req_in.rd
    |=> reg_rdata_out == 8'h00)
    else $error("read data without read");

  test_read_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    reg_req_in.rd && hit_test
    |=> reg_rdata_out == $past(test_r))
    else $error("test readback wrong");

  stat_read_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    reg_req_in.rd && hit_stat
    |=> reg_rdata_out == $past(status_w))
    else $error("status readback wrong");

  unmap_read_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    reg_req_in.rd && !hit_mask && !hit_test && !hit_stat
    |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");

  mask_write_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    wr_mask
    |=> mask_r == $past(reg_req_in.wdata))
    else $error("mask write lost");

  test_write_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    wr_test
    |=> test_r == $past(reg_req_in.wdata))
    else $error("test write lost");

  mask_hold_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !wr_mask
    |=> $stable(mask_r))
    else $error("mask changed without write");

  test_hold_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !wr_test
    |=> $stable(test_r))
    else $error("test changed without write");

  // No disable here: this one checks the reset itself
  rst_clear_a: assert property (@(posedge sys_clk_in)
    sys_rst_in
    |=> !m_valid_out && !s_ready_out && reg_rdata_out == 8'h00 && m_word_out == '0)
    else $error("outputs not cleared by reset");

endmodule

`default_nettype wire

// ### testbench/dtfe_src_model.sv
// Upstream source of overhead-tagged words for the transmit stage.
// Assumes the bench seeds $urandom and gates traffic with en_in.
`timescale 1ns/1ps
`default_nettype none
module dtfe_src_model import dtfe_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  input wire logic ready_in,
  output logic valid_out,
  output dtfe_bit_t word_out,
  output logic ext_out
);
  // Idle words change every cycle so a stale value never looks valid
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      valid_out <= 1'b0;
      word_out <= '0;
      ext_out <= 1'b0;
    end else if (!valid_out || ready_in) begin
      valid_out <= en_in;
      word_out <= dtfe_bit_t'(5'($urandom));
      ext_out <= 1'($urandom);
    end
  end
endmodule
`default_nettype wire

// ### testbench/test_dtfe_tx_oh.sv
// Self-checking bench for the transmit F-bit error / overhead insert stage.
// Assumes one 100 MHz clock; the bench is the register master and the receiver.
`timescale 1ns/1ps
`default_nettype none
module test_dtfe_tx_oh import dtfe_pkg::*;;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  dtfe_reg_req_t req = '0;
  logic [7:0] rdata, mdl_mask = 8'h00, mdl_test = 8'h00, d, m;
  logic s_valid, s_ready, ext, m_valid, m_rdy = 1'b1, en = 1'b0;
  dtfe_bit_t s_word, m_word;
  dtfe_bit_t exp_q[$];
  int failures = 0, tests_run = 0;
  dtfe_tx_oh dut_u (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .s_valid_in(s_valid), .s_ready_out(s_ready), .s_word_in(s_word),
    .ext_oh_bit_in(ext), .m_valid_out(m_valid), .m_ready_in(m_rdy), .m_word_out(m_word));
  dtfe_src_model src_u (.clk_in(sys_clk_in), .rst_in(sys_rst_in), .en_in(en),
    .ready_in(s_ready), .valid_out(s_valid), .word_out(s_word), .ext_out(ext));
  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_in) req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_in) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk_in) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_in) req <= '0;
    @(negedge sys_clk_in) v = rdata;
  endtask
  function automatic dtfe_bit_t model_out(dtfe_bit_t w, logic e);
    int p;
    p = w.pos;
    model_out = w;
    if (!mdl_test[OHSEL_BIT] && p >= 1 && p <= 6) model_out.data = w.data ^ mdl_mask[p-1];
    if (mdl_test[OHSEL_BIT] && p >= 9 && p <= 14 && !mdl_mask[p-9]) model_out.data = e;
  endfunction
  always @(posedge sys_clk_in) begin
    if (!sys_rst_in) begin
      if (s_valid && s_ready) exp_q.push_back(model_out(s_word, ext));
      if (m_valid && m_rdy) begin
        if (exp_q.size() == 0) chk({3'h0, m_word}, 8'hFF);
        else chk({3'h0, m_word}, {3'h0, exp_q.pop_front()});
      end
      if (req.wr && req.addr == REG_MASK_OFS) mdl_mask <= req.wdata;
      if (req.wr && req.addr == REG_TEST_OFS) mdl_test <= req.wdata;
    end
  end
  initial begin
    #200us;
    failures++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hf23e01b8));
    repeat (6) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    rd(REG_MASK_OFS, d);
    chk(d, MASK_RST);
    rd(REG_TEST_OFS, d);
    chk(d, TEST_RST);
    wr(8'h10, 8'hA5);
    rd(8'h10, d);
    chk(d, 8'h00);
    for (int i = 0; i < 8; i++) begin
      // Last pass: zero mask in error mode leaves every bit untouched
      m = (i == 7) ? 8'h00 : 8'($urandom);
      wr(REG_MASK_OFS, m);
      wr(REG_TEST_OFS, {i[0] && i != 7, 7'($urandom)});
      rd(REG_MASK_OFS, d);
      chk(d, m);
      rd(REG_TEST_OFS, d);
      chk(d, mdl_test);
      en <= 1'b1;
      repeat (150) @(posedge sys_clk_in) m_rdy <= 1'($urandom);
      @(posedge sys_clk_in) m_rdy <= 1'b0;
      repeat (10) @(posedge sys_clk_in);
      @(negedge sys_clk_in) chk({7'h00, s_ready}, 8'h00);
      rd(REG_STATUS_OFS, d);
      chk(d, 8'h03);
      en <= 1'b0;
      m_rdy <= 1'b1;
      for (int k = 0; k < 50 && (exp_q.size() != 0 || s_valid); k++) @(posedge sys_clk_in);
      chk(8'(exp_q.size()), 8'h00);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
